// File: src/psc_regs.sv
// Register bank: sequence checker control, clock multiplier tuning, receiver power-down
`timescale 1ns/100ps
`default_nettype none
`include "psc_params.svh"
module psc_regs
	import psc_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int LANES  = 8
) (
	// Clock and reset
	input  wire logic                           sys_clk,
	input  wire logic                           arst_n,
	// Register port
	input  wire logic [`PSC_ADDR_W-1:0]         reg_addr,
	input  wire logic                           reg_wr,
	input  wire logic [7:0]                     reg_wdata,
	input  wire logic                           reg_rd,
	output logic      [7:0]                     reg_rdata,
	output logic                                reg_rvalid,
	// Received test data
	input  wire logic [DATA_W-1:0]              rx_data,
	input  wire logic                           rx_valid,
	// Clock multiplier settings
	output logic      [8*`PSC_NUM_CLK_MULT-1:0] clk_mult_cfg,
	// Receiver power-down
	output logic                                receiver_bias_off,
	output logic      [LANES-1:0]               lane_receiver_off
);
	localparam int NCM = `PSC_NUM_CLK_MULT;
	localparam logic [`PSC_ADDR_W-1:0] CM_OFF [NCM] = '{
		`PSC_OFF_POWER_SET, `PSC_OFF_VAR_TUNE, `PSC_OFF_PUMP_ONE,
		`PSC_OFF_OSC_BIAS, `PSC_OFF_OSC_CTRL, `PSC_OFF_OSC_POWER,
		`PSC_OFF_OSC_CAL, `PSC_OFF_LOCK_CNT, `PSC_OFF_PUMP_TWO,
		`PSC_OFF_VAR_ONE, `PSC_OFF_VAR_TWO};
	localparam psc_byte_t CM_RST [NCM] = '{
		`PSC_RST_POWER_SET, `PSC_RST_VAR_TUNE, `PSC_RST_PUMP_ONE,
		`PSC_RST_OSC_BIAS, `PSC_RST_OSC_CTRL, `PSC_RST_OSC_POWER,
		`PSC_RST_OSC_CAL, `PSC_RST_LOCK_CNT, `PSC_RST_PUMP_TWO,
		`PSC_RST_VAR_ONE, `PSC_RST_VAR_TWO};
	localparam psc_byte_t CM_MASK [NCM] = '{
		`PSC_MASK_FULL, `PSC_MASK_FULL, `PSC_MASK_FULL,
		`PSC_MASK_OSC_BIAS, `PSC_MASK_FULL, `PSC_MASK_FULL,
		`PSC_MASK_FULL, `PSC_MASK_FULL, `PSC_MASK_FULL,
		`PSC_MASK_FULL, `PSC_MASK_FULL};
	localparam psc_byte_t CTRL_RST = `PSC_RST_CHK_CTRL;

	psc_chk_if  chk_bus ();

	logic       enable_reg;
	logic       clear_reg;
	logic       poly_reg;
	logic       global_off_reg;
	logic [7:0] lane_bits_reg;
	psc_byte_t  cm_reg [NCM];
	psc_byte_t  rdata_next;

	// Checker control fields
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			enable_reg <= CTRL_RST[`PSC_BIT_ENABLE];
			clear_reg  <= CTRL_RST[`PSC_BIT_CLEAR];
			poly_reg   <= CTRL_RST[`PSC_BIT_POLY];
		end else if (reg_wr && reg_addr == `PSC_OFF_CHK_CTRL) begin
			enable_reg <= reg_wdata[`PSC_BIT_ENABLE];
			clear_reg  <= reg_wdata[`PSC_BIT_CLEAR];
			poly_reg   <= reg_wdata[`PSC_BIT_POLY];
		end
	end

	assign chk_bus.enable = enable_reg;
	assign chk_bus.clear  = clear_reg;
	assign chk_bus.poly   = poly_reg ? PSC_POLY_LONG : PSC_POLY_SHORT;

	psc_seq_check #(
		.DATA_W (DATA_W)
	) u_check (
		.sys_clk  (sys_clk),
		.arst_n   (arst_n),
		.rx_data  (rx_data),
		.rx_valid (rx_valid),
		.chk      (chk_bus.chk)
	);

	psc_err_tally u_tally (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.tly     (chk_bus.tally)
	);

	// Clock multiplier tuning registers
	generate
		for (genvar g = 0; g < NCM; g++) begin : g_cm
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					cm_reg[g] <= CM_RST[g];
				end else if (reg_wr && reg_addr == CM_OFF[g]) begin
					cm_reg[g] <= reg_wdata & CM_MASK[g];
				end
			end
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					clk_mult_cfg[8*g +: 8] <= CM_RST[g];
				end else begin
					clk_mult_cfg[8*g +: 8] <= cm_reg[g];
				end
			end
		end
	endgenerate

	// Receiver power-down registers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			global_off_reg <= `PSC_RST_GLOBAL_PD;
		end else if (reg_wr && reg_addr == `PSC_OFF_GLOBAL_PD) begin
			global_off_reg <= reg_wdata[`PSC_BIT_GLOBAL_OFF];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lane_bits_reg <= `PSC_RST_LANE_PD;
		end else if (reg_wr && reg_addr == `PSC_OFF_LANE_PD) begin
			lane_bits_reg <= reg_wdata;
		end
	end

	// Power-down drive to the receiver
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			receiver_bias_off <= 1'b1;
			lane_receiver_off <= {LANES{1'b1}};
		end else begin
			receiver_bias_off <= global_off_reg;
			for (int i = 0; i < LANES; i++) begin
				lane_receiver_off[i] <= global_off_reg || lane_bits_reg[i];
			end
		end
	end

	// Read data selection
	always_comb begin
		rdata_next = 8'h00;
		case (reg_addr)
			`PSC_OFF_CHK_CTRL: begin
				rdata_next[`PSC_BIT_GOOD]   = chk_bus.good;
				rdata_next[`PSC_BIT_POLY]   = poly_reg;
				rdata_next[`PSC_BIT_CLEAR]  = clear_reg;
				rdata_next[`PSC_BIT_ENABLE] = enable_reg;
			end
			`PSC_OFF_ERR_COUNT: begin
				rdata_next = chk_bus.err_count;
			end
			`PSC_OFF_GLOBAL_PD: begin
				rdata_next[`PSC_BIT_GLOBAL_OFF] = global_off_reg;
			end
			`PSC_OFF_LANE_PD: begin
				rdata_next = lane_bits_reg;
			end
			default: begin
				for (int i = 0; i < NCM; i++) begin
					if (reg_addr == CM_OFF[i]) begin
						rdata_next = cm_reg[i];
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rdata_next;
			end
		end
	end
endmodule
`default_nettype wire

// File: src/psc_params.svh
// Register offsets, field positions and reset values for the sequence checker register bank
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH

`define PSC_ADDR_W           12
`define PSC_OFF_CHK_CTRL     12'h14B
`define PSC_OFF_ERR_COUNT    12'h14C
`define PSC_OFF_GLOBAL_PD    12'h200
`define PSC_OFF_LANE_PD      12'h201

`define PSC_BIT_ENABLE       0
`define PSC_BIT_CLEAR        1
`define PSC_BIT_POLY         2
`define PSC_BIT_GOOD         6
`define PSC_BIT_GLOBAL_OFF   0

`define PSC_RST_CHK_CTRL     8'h00
`define PSC_RST_ERR_COUNT    8'h00
`define PSC_RST_GLOBAL_PD    1'b1
`define PSC_RST_LANE_PD      8'h00

`define PSC_NUM_CLK_MULT     11
`define PSC_OFF_POWER_SET    12'h1B0
`define PSC_OFF_VAR_TUNE     12'h1B5
`define PSC_OFF_PUMP_ONE     12'h1B9
`define PSC_OFF_OSC_BIAS     12'h1BB
`define PSC_OFF_OSC_CTRL     12'h1BC
`define PSC_OFF_OSC_POWER    12'h1BE
`define PSC_OFF_OSC_CAL      12'h1BF
`define PSC_OFF_LOCK_CNT     12'h1C0
`define PSC_OFF_PUMP_TWO     12'h1C1
`define PSC_OFF_VAR_ONE      12'h1C4
`define PSC_OFF_VAR_TWO      12'h1C5

`define PSC_RST_POWER_SET    8'hFA
`define PSC_RST_VAR_TUNE     8'h83
`define PSC_RST_PUMP_ONE     8'h34
`define PSC_RST_OSC_BIAS     8'h0C
`define PSC_RST_OSC_CTRL     8'h00
`define PSC_RST_OSC_POWER    8'h00
`define PSC_RST_OSC_CAL      8'h8D
`define PSC_RST_LOCK_CNT     8'h2E
`define PSC_RST_PUMP_TWO     8'h24
`define PSC_RST_VAR_ONE      8'h33
`define PSC_RST_VAR_TWO      8'h08

`define PSC_MASK_FULL        8'hFF
`define PSC_MASK_OSC_BIAS    8'h1F

`endif

// File: src/psc_pkg.sv
// Types shared by the sequence checker register bank
`default_nettype none
package psc_pkg;
	typedef logic [7:0] psc_byte_t;
	typedef enum logic {
		PSC_POLY_SHORT,
		PSC_POLY_LONG
	} psc_poly_e;
endpackage
`default_nettype wire

// File: src/psc_chk_if.sv
// Control and status bundle between the register bank and the sequence checker
`timescale 1ns/100ps
`default_nettype none
interface psc_chk_if;
	import psc_pkg::*;
	logic      enable;
	logic      clear;
	psc_poly_e poly;
	logic      word_seen;
	logic      mismatch;
	logic      good;
	psc_byte_t err_count;
	modport ctl (output enable, output clear, output poly, input good, input err_count);
	modport chk (input enable, input poly, output word_seen, output mismatch, output good);
	modport tally (input enable, input clear, input word_seen, input mismatch,
		output err_count);
endinterface
`default_nettype wire

// File: src/psc_seq_check.sv
// Self-synchronising pseudo-random sequence checker on received words
`timescale 1ns/100ps
`default_nettype none
module psc_seq_check
	import psc_pkg::*;
#(
	parameter int DATA_W = 16
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	// Received data
	input  wire logic [DATA_W-1:0] rx_data,
	input  wire logic              rx_valid,
	// Control and status
	psc_chk_if.chk                 chk
);
	logic [14:0] hist_reg;
	logic [14:0] hist_next;
	logic        miss_next;

	// Predict each bit from earlier received bits, oldest bit first
	always_comb begin
		logic pred;
		pred = 1'b0;
		hist_next = hist_reg;
		miss_next = 1'b0;
		for (int i = DATA_W - 1; i >= 0; i--) begin
			if (chk.poly == PSC_POLY_LONG) begin
				pred = hist_next[14] ^ hist_next[13];
			end else begin
				pred = hist_next[6] ^ hist_next[5];
			end
			if (pred != rx_data[i]) begin
				miss_next = 1'b1;
			end
			hist_next = {hist_next[13:0], rx_data[i]};
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			hist_reg <= 15'h0000;
		end else if (chk.enable && rx_valid) begin
			hist_reg <= hist_next;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			chk.word_seen <= 1'b0;
			chk.mismatch  <= 1'b0;
		end else begin
			chk.word_seen <= chk.enable && rx_valid;
			chk.mismatch  <= chk.enable && rx_valid && miss_next;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			chk.good <= 1'b0;
		end else if (chk.enable && rx_valid) begin
			chk.good <= !miss_next;
		end
	end
endmodule
`default_nettype wire

// File: src/psc_err_tally.sv
// Saturating error counter for the sequence checker
`timescale 1ns/100ps
`default_nettype none
`include "psc_params.svh"
module psc_err_tally
	import psc_pkg::*;
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic arst_n,
	// Control and status
	psc_chk_if.tally  tly
);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tly.err_count <= `PSC_RST_ERR_COUNT;
		end else if (tly.clear) begin
			tly.err_count <= `PSC_RST_ERR_COUNT;
		end else if (tly.enable && tly.word_seen && tly.mismatch
				&& tly.err_count != 8'hFF) begin
			tly.err_count <= tly.err_count + 8'h01;
		end
	end
endmodule
`default_nettype wire

// File: tb/psc_regs_chk.sv
// Assertions on the register bank ports
`timescale 1ns/100ps
`default_nettype none
`include "psc_params.svh"
module psc_regs_chk
	import psc_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int LANES  = 8
) (
	// Clock and reset
	input wire logic                           sys_clk,
	input wire logic                           arst_n,
	// Register port
	input wire logic [`PSC_ADDR_W-1:0]         reg_addr,
	input wire logic                           reg_wr,
	input wire logic [7:0]                     reg_wdata,
	input wire logic                           reg_rd,
	input wire logic [7:0]                     reg_rdata,
	input wire logic                           reg_rvalid,
	// Data and outputs
	input wire logic [DATA_W-1:0]              rx_data,
	input wire logic                           rx_valid,
	input wire logic [8*`PSC_NUM_CLK_MULT-1:0] clk_mult_cfg,
	input wire logic                           receiver_bias_off,
	input wire logic [LANES-1:0]               lane_receiver_off
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	sequence wr_idle(a);
		reg_wr && reg_addr == a ##1 !reg_wr;
	endsequence
	a_rvalid_pulse: assert property (reg_rvalid == $past(reg_rd))
		else $error("read valid not one cycle after read");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	a_ctrl_ro_zero: assert property (reg_rd && reg_addr == 12'h14B |=>
		reg_rdata[7] == 1'b0 && reg_rdata[5:3] == 3'h0) else $error("control spare bits set");
	a_ctrl_read_back: assert property (wr_idle(12'h14B) ##1 reg_rd && reg_addr == 12'h14B
		|=> reg_rdata[2:0] == $past(reg_wdata[2:0], 3)) else $error("control bits lost");
	a_clear_zeroes: assert property (reg_wr && reg_addr == 12'h14B && reg_wdata[1] ##1 !reg_wr
		##1 reg_rd && reg_addr == 12'h14C |=> reg_rdata == 8'h00) else $error("count not cleared");
	a_global_read: assert property (reg_rd && reg_addr == 12'h200 |=>
		reg_rdata == {7'h00, receiver_bias_off}) else $error("global power-down read wrong");
	a_global_lanes: assert property (receiver_bias_off |-> &lane_receiver_off)
		else $error("lane on while global off");
	a_lane_write: assert property (wr_idle(12'h201) ##1 !reg_wr && !receiver_bias_off
		|-> lane_receiver_off == $past(reg_wdata, 2)) else $error("lane power-down wrong");
	a_cfg_write: assert property (wr_idle(12'h1C4) ##1 !reg_wr
		|-> clk_mult_cfg[79:72] == $past(reg_wdata, 2)) else $error("tuning byte wrong");
endmodule
bind psc_regs psc_regs_chk #(.DATA_W(DATA_W), .LANES(LANES)) chk_u (.sys_clk(sys_clk),
	.arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_data(rx_data),
	.rx_valid(rx_valid), .clk_mult_cfg(clk_mult_cfg), .receiver_bias_off(receiver_bias_off),
	.lane_receiver_off(lane_receiver_off));
`default_nettype wire

// File: tb/psc_sequence_checker_control_src.sv
// Far-side transmitter model sending pseudo-random test words
`timescale 1ns/100ps
`default_nettype none
module psc_sequence_checker_control_src #(
	parameter int DATA_W = 16
) (
	// Clock
	input  wire logic              sys_clk,
	// Control from the bench
	input  wire logic              run,
	input  wire logic              poly,
	input  wire logic              flip,
	// Test words
	output logic      [DATA_W-1:0] rx_data,
	output logic                   rx_valid
);
	logic [14:0] hist = 15'h7FFF;
	logic        b;
	initial begin
		rx_data = '0;
		rx_valid = 1'b0;
	end
	always @(negedge sys_clk) begin
		rx_valid <= run;
		if (run) begin
			for (int i = DATA_W - 1; i >= 0; i--) begin
				b = poly ? hist[14] ^ hist[13] : hist[6] ^ hist[5];
				rx_data[i] <= b ^ (flip && i == DATA_W - 1);
				hist = {hist[13:0], b};
			end
		end else begin
			rx_data <= ~rx_data;
		end
	end
endmodule
`default_nettype wire

// File: tb/psc_regs_tb_top.sv
// Self-checking bench for the register bank
`timescale 1ns/100ps
`default_nettype none
module psc_regs_tb_top;
	import psc_pkg::*;
	logic        sys_clk = 0;
	logic        arst_n = 0;
	logic [11:0] reg_addr = 0;
	logic        reg_wr = 0;
	logic [7:0]  reg_wdata = 0;
	logic        reg_rd = 0;
	logic [7:0]  reg_rdata;
	logic        reg_rvalid;
	logic [15:0] rx_data;
	logic        rx_valid;
	logic [87:0] cfg;
	logic        bias_off;
	logic [7:0]  lanes;
	logic        run = 0;
	logic        poly = 0;
	logic        flip = 0;
	logic [7:0]  v;
	int          n_mismatch = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          n;
	logic [11:0] ra [15] = '{12'h14B, 12'h14C, 12'h1B0, 12'h1B5, 12'h1B9, 12'h1BB, 12'h1BC,
		12'h1BE, 12'h1BF, 12'h1C0, 12'h1C1, 12'h1C4, 12'h1C5, 12'h200, 12'h201};
	logic [7:0]  rv [15] = '{8'h00, 8'h00, 8'hFA, 8'h83, 8'h34, 8'h0C, 8'h00, 8'h00, 8'h8D,
		8'h2E, 8'h24, 8'h33, 8'h08, 8'h01, 8'h00};
	logic [7:0]  sw [15] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h24, 8'h00, 8'h0D, 8'h02, 8'h8E,
		8'h2A, 8'h2A, 8'h7E, 8'h00, 8'h00, 8'h00};
	psc_regs #(.DATA_W(16), .LANES(8)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_data(rx_data), .rx_valid(rx_valid),
		.clk_mult_cfg(cfg), .receiver_bias_off(bias_off), .lane_receiver_off(lanes));
	psc_sequence_checker_control_src #(.DATA_W(16)) src_u (.sys_clk(sys_clk), .run(run), .poly(poly), .flip(flip),
		.rx_data(rx_data), .rx_valid(rx_valid));
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	function automatic logic [7:0] ctl(logic g, logic p, logic c, logic e);
		return {1'b0, g, 3'h0, p, c, e};
	endfunction
	function automatic logic [7:0] sat(int k);
		return k > 255 ? 8'hFF : 8'(k);
	endfunction
	task chk8(logic [7:0] got, logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(logic [11:0] a, logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge sys_clk);
		reg_wr = 0;
	endtask
	task rdc(logic [11:0] a, logic [7:0] exp);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1;
		@(negedge sys_clk);
		reg_rd = 0;
		chk8({7'h00, reg_rvalid}, 8'h01);
		chk8(reg_rdata, exp);
	endtask
	task send(int k, logic f);
		@(negedge sys_clk);
		run <= 1;
		flip <= f;
		repeat (k) @(negedge sys_clk);
		run <= 0;
		flip <= 0;
		repeat (3) @(negedge sys_clk);
	endtask
	task report_and_stop();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h3E25));
		repeat (12) @(negedge sys_clk);
		arst_n = 1;
		for (int i = 0; i < 15; i++) rdc(ra[i], rv[i]);
		$display("test reset values done");
		for (int i = 2; i < 13; i++) begin
			chk8(cfg[8*(i-2) +: 8], rv[i]);
			n = $urandom;
			v = i == 3 ? {4'h8, 4'(n)} : (i == 5 || i == 12) ? 8'(n) : sw[i];
			wr(ra[i], v);
			rdc(ra[i], i == 5 ? v & 8'h1F : v);
			chk8(cfg[8*(i-2) +: 8], i == 5 ? v & 8'h1F : v);
		end
		wr(12'h14C, 8'hFF);
		rdc(12'h14C, 8'h00);
		rdc(12'h150, 8'h00);
		$display("test tuning done");
		chk8(lanes, 8'hFF);
		chk8({7'h00, bias_off}, 8'h01);
		wr(12'h200, 8'hFE);
		rdc(12'h200, 8'h00);
		chk8({7'h00, bias_off}, 8'h00);
		v = 8'($urandom);
		wr(12'h201, v);
		rdc(12'h201, v);
		chk8(lanes, v);
		wr(12'h200, 8'h01);
		rdc(12'h200, 8'h01);
		chk8(lanes, 8'hFF);
		chk8({7'h00, bias_off}, 8'h01);
		$display("test power-down done");
		for (int p = 0; p < 2; p++) begin
			poly <= p[0];
			wr(12'h14B, ctl(0, p[0], 1, 1));
			send(4, 0);
			wr(12'h14B, ctl(0, p[0], 0, 1));
			send(4, 0);
			rdc(12'h14B, ctl(1, p[0], 0, 1));
			rdc(12'h14C, 8'h00);
			n = $urandom_range(20, 1);
			repeat (n) begin
				send(1, 0);
				send(1, 1);
			end
			rdc(12'h14B, ctl(0, p[0], 0, 1));
			rdc(12'h14C, sat(n));
			wr(12'h14B, ctl(0, p[0], 0, 0));
			send(3, 1);
			rdc(12'h14C, sat(n));
			wr(12'h14B, ctl(0, p[0], 0, 1));
			send(300, 1);
			rdc(12'h14C, sat(n + 300));
			wr(12'h14B, ctl(0, p[0], 1, 1));
			rdc(12'h14C, 8'h00);
			$display("test checker poly %0d done", p);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
